// ---- wbps_pkg.sv ----
/*
 Shared constants and state codes for the write-buffer program sequencer,
 its flash command port and the host-side controller.
 Assumes 16-bit flash words and word addressing on the command port.
*/
package wbps_pkg;
  localparam int ADDR_W = 12;
  localparam int BUF_WORDS = 32;
  localparam int PAGE_LSB = 5;
  localparam int SECT_LSB = 8;
  localparam int UNLK_W = 12;
  localparam logic [11:0] UNLK1_ADDR = 12'h555;
  localparam logic [11:0] UNLK2_ADDR = 12'h2AA;
  localparam logic [15:0] UNLK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLK2_DATA = 16'h0055;
  localparam logic [15:0] CMD_LOAD = 16'h0025;
  localparam logic [15:0] CMD_CONFIRM = 16'h0029;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Status word bit positions
  localparam int STS_POLL = 7;
  localparam int STS_TOGGLE = 6;
  localparam int STS_LIMIT = 5;
  localparam int STS_ALT = 2;
  localparam int STS_ABORT = 1;
  // Embedded program time per word
  localparam int CLK_MHZ = 10;
  localparam int PROG_WORD_NS = 1000;
  localparam int PROG_WORD_CYC = (PROG_WORD_NS * CLK_MHZ + 999) / 1000;
  // Host register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_LAST = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT_RST = 1;
  localparam int CTRL_SUSPEND = 2;
  localparam int CTRL_RESUME = 3;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_LIMIT = 2;

  typedef enum logic [3:0] {
    D_READ = 4'h0, D_UNLK1 = 4'h1, D_UNLK2 = 4'h2, D_COUNT = 4'h3,
    D_LOAD = 4'h4, D_CONFIRM = 4'h5, D_PROG = 4'h6, D_SUSP = 4'h7,
    D_ABORT = 4'h8, D_ARST1 = 4'h9, D_ARST2 = 4'hA, D_LIMIT = 4'hB
  } wbps_dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_SEND = 3'h1, H_POLL = 3'h2, H_WAIT = 3'h3,
    H_ARST = 3'h4, H_CMD = 3'h5
  } wbps_host_st_t;
endpackage : wbps_pkg

// ---- wbps_if.sv ----
/*
 Flash command port between the host controller and the sequencer.
 Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
interface wbps_if #(parameter int ADDR_W = wbps_pkg::ADDR_W);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0] wr_data;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [15:0] rd_data;
  logic rd_valid;
  logic busy;
  modport dev (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
               output rd_data, rd_valid, busy);
  modport host (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input rd_data, rd_valid, busy);
endinterface : wbps_if

// ---- wbps_device.sv ----
/*
 Flash-side write-buffer program sequencer with its array and page buffer.
 Assumes the host drives one command write per wr_en pulse, synchronous to hclk.
*/
// Functional notes
// - One to 32 words programmed in one operation
// - Host starts with two unlock writes
// - Third write is load command in sector
// - Fourth write gives word count minus one
// - Count beyond buffer size aborts
// - First load fixes page; later loads match
// - Foreign page or sector during loading aborts
// - Every load decrements; last data wins
// - Confirm at sector address, else abort
// - Busy while programming, then read mode
// - Abort status: flag, inverted poll, toggling
// - Host polls status at last loaded address
// - Programming may be suspended and resumed
// - Abort cleared only by abort-reset sequence
// - No special regions entered while programming
// - Reprogramming and any address order allowed
// - Only suspend accepted while programming
// - Zero-to-one attempt sets limit, halts
`timescale 1ns/100ps
module wbps_device #(
  parameter int ADDR_W = wbps_pkg::ADDR_W,
  parameter int BUF_WORDS = wbps_pkg::BUF_WORDS,
  parameter int PROG_CYC = wbps_pkg::PROG_WORD_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flash command port
  wbps_if.dev bus,
  // User-side status
  output logic busy,
  output logic aborted,
  output logic limit_hit
);
  localparam int PL = wbps_pkg::PAGE_LSB;
  localparam int SL = wbps_pkg::SECT_LSB;
  localparam int UW = wbps_pkg::UNLK_W;

  typedef struct packed {
    wbps_pkg::wbps_dev_st_t st;
    logic [ADDR_W-1:SL] sect;
    logic [ADDR_W-1:PL] page;
    logic page_set;
    logic [5:0] left;
    logic [PL-1:0] idx;
    logic [15:0] tmr;
    logic [BUF_WORDS-1:0] vld;
    logic [15:0] last_data;
    logic tog;
    logic [15:0] rdata;
    logic rvalid;
  } wbps_dev_state_t;

  wbps_dev_state_t s_r;
  wbps_dev_state_t s_nxt;
  logic [15:0] mem [0:(1<<ADDR_W)-1];
  logic [15:0] bufm [0:BUF_WORDS-1];
  logic mem_we;
  logic buf_we;
  logic wr_sect;
  logic wr_page;
  logic unl1;
  logic unl2;
  logic [15:0] prog_word;
  logic [15:0] old_word;
  logic [15:0] sts;
  logic status_mode;

  // Array powers up erased; no erase path in this block
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = wbps_pkg::ERASED_WORD;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'h0;
    mem_we = 1'h0;
    buf_we = 1'h0;
    wr_sect = bus.wr_addr[ADDR_W-1:SL] == s_r.sect;
    wr_page = bus.wr_addr[ADDR_W-1:PL] == s_r.page;
    unl1 = (bus.wr_addr[UW-1:0] == wbps_pkg::UNLK1_ADDR)
           && (bus.wr_data == wbps_pkg::UNLK1_DATA);
    unl2 = (bus.wr_addr[UW-1:0] == wbps_pkg::UNLK2_ADDR)
           && (bus.wr_data == wbps_pkg::UNLK2_DATA);
    prog_word = bufm[s_r.idx];
    old_word = mem[{s_r.page, s_r.idx}];
    case (s_r.st)
      wbps_pkg::D_READ: begin
        if (bus.wr_en && unl1) begin
          s_nxt.st = wbps_pkg::D_UNLK1;
        end
      end
      wbps_pkg::D_UNLK1: begin
        if (bus.wr_en) begin
          s_nxt.st = unl2 ? wbps_pkg::D_UNLK2 : wbps_pkg::D_READ;
        end
      end
      wbps_pkg::D_UNLK2: begin
        if (bus.wr_en && bus.wr_data == wbps_pkg::CMD_LOAD) begin
          s_nxt.st = wbps_pkg::D_COUNT;
          s_nxt.sect = bus.wr_addr[ADDR_W-1:SL];
        end else if (bus.wr_en) begin
          s_nxt.st = wbps_pkg::D_READ;
        end
      end
      wbps_pkg::D_COUNT: begin
        if (bus.wr_en) begin
          if (!wr_sect || bus.wr_data > 16'(BUF_WORDS - 1)) begin
            s_nxt.st = wbps_pkg::D_ABORT;
          end else begin
            s_nxt.st = wbps_pkg::D_LOAD;
            s_nxt.left = 6'(bus.wr_data) + 6'h01;
            s_nxt.vld = '0;
            s_nxt.page_set = 1'h0;
          end
        end
      end
      wbps_pkg::D_LOAD: begin
        if (bus.wr_en) begin
          if (!wr_sect || (s_r.page_set && !wr_page)) begin
            s_nxt.st = wbps_pkg::D_ABORT;
          end else begin
            if (!s_r.page_set) begin
              s_nxt.page = bus.wr_addr[ADDR_W-1:PL];
            end
            s_nxt.page_set = 1'h1;
            buf_we = 1'h1;
            s_nxt.vld[bus.wr_addr[PL-1:0]] = 1'h1;
            s_nxt.last_data = bus.wr_data;
            s_nxt.left = s_r.left - 6'h01;
            if (s_r.left == 6'h01) begin
              s_nxt.st = wbps_pkg::D_CONFIRM;
            end
          end
        end
      end
      wbps_pkg::D_CONFIRM: begin
        if (bus.wr_en) begin
          if (wr_sect && bus.wr_data == wbps_pkg::CMD_CONFIRM) begin
            s_nxt.st = wbps_pkg::D_PROG;
            s_nxt.idx = '0;
            s_nxt.tmr = 16'(PROG_CYC - 1);
          end else begin
            s_nxt.st = wbps_pkg::D_ABORT;
          end
        end
      end
      wbps_pkg::D_PROG: begin
        // Every other command, including region entry, is dropped here
        if (bus.wr_en && bus.wr_data == wbps_pkg::CMD_SUSPEND) begin
          s_nxt.st = wbps_pkg::D_SUSP;
        end else if (s_r.tmr != 16'h0000) begin
          s_nxt.tmr = s_r.tmr - 16'h0001;
        end else begin
          s_nxt.tmr = 16'(PROG_CYC - 1);
          s_nxt.idx = s_r.idx + 1'h1;
          if (s_r.vld[s_r.idx] && ((~old_word & prog_word) != 16'h0000)) begin
            s_nxt.st = wbps_pkg::D_LIMIT;
          end else begin
            // No erase needed: only ones are cleared
            mem_we = s_r.vld[s_r.idx];
            if (s_r.idx == PL'(BUF_WORDS - 1)) begin
              s_nxt.st = wbps_pkg::D_READ;
            end
          end
        end
      end
      wbps_pkg::D_SUSP: begin
        if (bus.wr_en && bus.wr_data == wbps_pkg::CMD_RESUME) begin
          s_nxt.st = wbps_pkg::D_PROG;
        end
      end
      wbps_pkg::D_ABORT: begin
        if (bus.wr_en && unl1) begin
          s_nxt.st = wbps_pkg::D_ARST1;
        end
      end
      wbps_pkg::D_ARST1: begin
        if (bus.wr_en) begin
          s_nxt.st = unl2 ? wbps_pkg::D_ARST2 : wbps_pkg::D_ABORT;
        end
      end
      wbps_pkg::D_ARST2: begin
        if (bus.wr_en) begin
          if (bus.wr_addr[UW-1:0] == wbps_pkg::UNLK1_ADDR
              && bus.wr_data == wbps_pkg::CMD_RESET) begin
            s_nxt.st = wbps_pkg::D_READ;
          end else begin
            s_nxt.st = wbps_pkg::D_ABORT;
          end
        end
      end
      wbps_pkg::D_LIMIT: begin
        if (bus.wr_en && bus.wr_data == wbps_pkg::CMD_RESET) begin
          s_nxt.st = wbps_pkg::D_READ;
        end
      end
      default: begin
        s_nxt.st = wbps_pkg::D_READ;
      end
    endcase

    // Status word in place of array data while busy, aborted or halted
    status_mode = (s_r.st == wbps_pkg::D_PROG) || (s_r.st == wbps_pkg::D_LIMIT)
                  || (s_r.st == wbps_pkg::D_ABORT) || (s_r.st == wbps_pkg::D_ARST1)
                  || (s_r.st == wbps_pkg::D_ARST2);
    sts = 16'h0000;
    sts[wbps_pkg::STS_POLL] = ~s_r.last_data[wbps_pkg::STS_POLL];
    sts[wbps_pkg::STS_TOGGLE] = s_r.tog;
    sts[wbps_pkg::STS_ALT] = s_r.tog;
    sts[wbps_pkg::STS_LIMIT] = s_r.st == wbps_pkg::D_LIMIT;
    sts[wbps_pkg::STS_ABORT] = (s_r.st == wbps_pkg::D_ABORT)
                               || (s_r.st == wbps_pkg::D_ARST1)
                               || (s_r.st == wbps_pkg::D_ARST2);
    if (bus.rd_en) begin
      s_nxt.rvalid = 1'h1;
      if (status_mode) begin
        s_nxt.rdata = sts;
        s_nxt.tog = ~s_r.tog;
      end else begin
        s_nxt.rdata = mem[bus.rd_addr];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Arrays kept outside the reset struct: too wide to clear in one cycle
  // Plain always: the array is also preset by the power-up block
  always @(posedge hclk) begin
    if (buf_we) begin
      bufm[bus.wr_addr[PL-1:0]] <= bus.wr_data;
    end
    if (mem_we) begin
      mem[{s_r.page, s_r.idx}] <= prog_word;
    end
  end

  assign bus.rd_data = s_r.rdata;
  assign bus.rd_valid = s_r.rvalid;
  assign bus.busy = s_r.st == wbps_pkg::D_PROG;
  assign busy = s_r.st == wbps_pkg::D_PROG;
  assign aborted = s_r.st == wbps_pkg::D_ABORT || s_r.st == wbps_pkg::D_ARST1
                   || s_r.st == wbps_pkg::D_ARST2;
  assign limit_hit = s_r.st == wbps_pkg::D_LIMIT;
endmodule : wbps_device

// ---- wbps_host.sv ----
/*
 Host-side controller: AHB-Lite register slave that issues write-buffer
 program sequences on the flash command port and polls for the outcome.
 Assumes a single AHB-Lite master and a zero-wait slave response.
*/
`timescale 1ns/100ps
module wbps_host #(
  parameter int ADDR_W = wbps_pkg::ADDR_W,
  parameter int BUF_WORDS = wbps_pkg::BUF_WORDS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq,
  // Flash command port
  wbps_if.host bus
);
  localparam int IW = wbps_pkg::IRQ_W;

  typedef struct packed {
    wbps_pkg::wbps_host_st_t st;
    logic [5:0] step;
    logic resume;
    logic a_vld;
    logic a_wr;
    logic [7:0] a_addr;
    logic [ADDR_W-1:0] base;
    logic [5:0] cnt;
    logic [4:0] fill;
    logic [15:0] last;
    logic [IW-1:0] irq_st;
    logic [IW-1:0] irq_mask;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
  } wbps_host_state_t;

  wbps_host_state_t s_r;
  wbps_host_state_t s_nxt;
  logic [15:0] dmem [0:BUF_WORDS-1];
  logic dmem_we;
  logic [4:0] lm;
  logic [5:0] ld;
  logic [IW-1:0] set;
  logic [IW-1:0] clr;
  logic wr_ph;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_en = 1'h0;
    s_nxt.rd_en = 1'h0;
    set = '0;
    clr = '0;
    dmem_we = 1'h0;
    // Oversized counts still send 32 loads; the flash aborts on the count
    lm = (s_r.cnt > 6'(BUF_WORDS - 1)) ? 5'(BUF_WORDS - 1) : s_r.cnt[4:0];
    ld = s_r.step - 6'h04;
    case (s_r.st)
      wbps_pkg::H_SEND: begin
        s_nxt.wr_en = 1'h1;
        s_nxt.step = s_r.step + 6'h01;
        if (s_r.step == 6'h00) begin
          s_nxt.wr_addr = ADDR_W'(wbps_pkg::UNLK1_ADDR);
          s_nxt.wr_data = wbps_pkg::UNLK1_DATA;
        end else if (s_r.step == 6'h01) begin
          s_nxt.wr_addr = ADDR_W'(wbps_pkg::UNLK2_ADDR);
          s_nxt.wr_data = wbps_pkg::UNLK2_DATA;
        end else if (s_r.step == 6'h02) begin
          s_nxt.wr_addr = s_r.base;
          s_nxt.wr_data = wbps_pkg::CMD_LOAD;
        end else if (s_r.step == 6'h03) begin
          s_nxt.wr_addr = s_r.base;
          s_nxt.wr_data = 16'(s_r.cnt);
        end else if (s_r.step <= {1'h0, lm} + 6'h04) begin
          s_nxt.wr_addr = s_r.base + ADDR_W'(ld);
          s_nxt.wr_data = dmem[ld[4:0]];
        end else begin
          s_nxt.wr_addr = s_r.base;
          s_nxt.wr_data = wbps_pkg::CMD_CONFIRM;
          s_nxt.st = wbps_pkg::H_POLL;
        end
      end
      wbps_pkg::H_POLL: begin
        s_nxt.rd_en = 1'h1;
        s_nxt.rd_addr = s_r.base + ADDR_W'(lm);
        s_nxt.st = wbps_pkg::H_WAIT;
      end
      wbps_pkg::H_WAIT: begin
        if (bus.rd_valid) begin
          s_nxt.last = bus.rd_data;
          s_nxt.st = wbps_pkg::H_IDLE;
          if (bus.rd_data == dmem[lm]) begin
            set[wbps_pkg::IRQ_DONE] = 1'h1;
          end else if (bus.rd_data[wbps_pkg::STS_ABORT]) begin
            set[wbps_pkg::IRQ_ABORT] = 1'h1;
          end else if (bus.rd_data[wbps_pkg::STS_LIMIT]) begin
            set[wbps_pkg::IRQ_LIMIT] = 1'h1;
          end else begin
            s_nxt.st = wbps_pkg::H_POLL;
          end
        end
      end
      wbps_pkg::H_ARST: begin
        s_nxt.wr_en = 1'h1;
        s_nxt.step = s_r.step + 6'h01;
        if (s_r.step == 6'h00) begin
          s_nxt.wr_addr = ADDR_W'(wbps_pkg::UNLK1_ADDR);
          s_nxt.wr_data = wbps_pkg::UNLK1_DATA;
        end else if (s_r.step == 6'h01) begin
          s_nxt.wr_addr = ADDR_W'(wbps_pkg::UNLK2_ADDR);
          s_nxt.wr_data = wbps_pkg::UNLK2_DATA;
        end else begin
          s_nxt.wr_addr = ADDR_W'(wbps_pkg::UNLK1_ADDR);
          s_nxt.wr_data = wbps_pkg::CMD_RESET;
          s_nxt.st = wbps_pkg::H_IDLE;
        end
      end
      wbps_pkg::H_CMD: begin
        s_nxt.wr_en = 1'h1;
        s_nxt.wr_addr = s_r.base;
        s_nxt.wr_data = s_r.resume ? wbps_pkg::CMD_RESUME : wbps_pkg::CMD_SUSPEND;
        s_nxt.st = s_r.resume ? wbps_pkg::H_POLL : wbps_pkg::H_IDLE;
      end
      default: begin
        s_nxt.st = wbps_pkg::H_IDLE;
      end
    endcase

    // Register writes land in the data phase
    wr_ph = s_r.a_vld && s_r.a_wr;
    if (wr_ph && s_r.a_addr == wbps_pkg::REG_CTRL) begin
      if (s_r.st == wbps_pkg::H_IDLE && hwdata[wbps_pkg::CTRL_START]) begin
        s_nxt.st = wbps_pkg::H_SEND;
        s_nxt.step = '0;
        s_nxt.fill = '0;
      end else if (s_r.st == wbps_pkg::H_IDLE && hwdata[wbps_pkg::CTRL_ABORT_RST]) begin
        s_nxt.st = wbps_pkg::H_ARST;
        s_nxt.step = '0;
      end else if (s_r.st == wbps_pkg::H_IDLE && hwdata[wbps_pkg::CTRL_RESUME]) begin
        s_nxt.st = wbps_pkg::H_CMD;
        s_nxt.resume = 1'h1;
      end else if ((s_r.st == wbps_pkg::H_POLL || s_r.st == wbps_pkg::H_WAIT)
                   && hwdata[wbps_pkg::CTRL_SUSPEND]) begin
        s_nxt.st = wbps_pkg::H_CMD;
        s_nxt.resume = 1'h0;
      end
    end else if (wr_ph && s_r.a_addr == wbps_pkg::REG_BASE) begin
      s_nxt.base = hwdata[ADDR_W-1:0];
    end else if (wr_ph && s_r.a_addr == wbps_pkg::REG_COUNT) begin
      s_nxt.cnt = hwdata[5:0];
    end else if (wr_ph && s_r.a_addr == wbps_pkg::REG_DATA) begin
      dmem_we = 1'h1;
      s_nxt.fill = s_r.fill + 5'h01;
    end else if (wr_ph && s_r.a_addr == wbps_pkg::REG_IRQ_STAT) begin
      clr = hwdata[IW-1:0];
    end else if (wr_ph && s_r.a_addr == wbps_pkg::REG_IRQ_MASK) begin
      s_nxt.irq_mask = hwdata[IW-1:0];
    end
    // A new event wins over a clear in the same cycle
    s_nxt.irq_st = (s_r.irq_st & ~clr) | set;

    if (hready) begin
      s_nxt.a_vld = hsel && htrans[1];
      s_nxt.a_wr = hwrite;
      s_nxt.a_addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge hclk) begin
    if (dmem_we) begin
      dmem[s_r.fill] <= hwdata[15:0];
    end
  end

  // Read mux over registered state; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h00000000;
    if (s_r.a_vld && !s_r.a_wr) begin
      if (s_r.a_addr == wbps_pkg::REG_CTRL) begin
        hrdata = 32'({bus.busy, s_r.st != wbps_pkg::H_IDLE});
      end else if (s_r.a_addr == wbps_pkg::REG_BASE) begin
        hrdata = 32'(s_r.base);
      end else if (s_r.a_addr == wbps_pkg::REG_COUNT) begin
        hrdata = 32'(s_r.cnt);
      end else if (s_r.a_addr == wbps_pkg::REG_DATA) begin
        hrdata = 32'(s_r.fill);
      end else if (s_r.a_addr == wbps_pkg::REG_LAST) begin
        hrdata = 32'(s_r.last);
      end else if (s_r.a_addr == wbps_pkg::REG_IRQ_STAT) begin
        hrdata = 32'(s_r.irq_st);
      end else if (s_r.a_addr == wbps_pkg::REG_IRQ_MASK) begin
        hrdata = 32'(s_r.irq_mask);
      end
    end
  end

  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign irq = |(s_r.irq_st & s_r.irq_mask);
  assign bus.wr_en = s_r.wr_en;
  assign bus.wr_addr = s_r.wr_addr;
  assign bus.wr_data = s_r.wr_data;
  assign bus.rd_en = s_r.rd_en;
  assign bus.rd_addr = s_r.rd_addr;
endmodule : wbps_host

// ---- wbps_checker.sv ----
/*
 Checker for the flash command port between host and sequencer.
 Assumes it watches the joining interface and the device status, on hclk.
*/
`timescale 1ns/100ps
module wbps_checker #(
  parameter int ADDR_W = wbps_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic busy,
  // Device status
  input wire logic aborted,
  input wire logic limit_hit
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RD_ANSWER: assert property (rd_valid == $past(rd_en))
    else $error("read answer late or spurious");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(wr_en) &&
    ($past(wr_data) == wbps_pkg::CMD_CONFIRM || $past(wr_data) == wbps_pkg::CMD_RESUME))
    else $error("busy without confirm");
  AST_BUSY_ENDS: assert property ($rose(busy) |-> ##[1:300] !busy)
    else $error("programming never ends");
  AST_BUSY_CLEAN: assert property (busy |-> !aborted && !limit_hit)
    else $error("busy mixed with fault");
  AST_SUSPEND: assert property (busy && wr_en && wr_data == wbps_pkg::CMD_SUSPEND |=> !busy)
    else $error("suspend not taken");
  // Host sends the sequence back to back, so fixed spacing is enough
  AST_COUNT_ABORT: assert property (wr_en && wr_data == wbps_pkg::UNLK2_DATA
    ##1 wr_en && wr_data == wbps_pkg::CMD_LOAD ##1 wr_en && wr_data > 16'h001F |=> aborted)
    else $error("oversize count not aborted");
  AST_ABORT_STATUS: assert property (rd_en && aborted |=> rd_data[1] && !rd_data[5])
    else $error("abort status wrong");
  // Host poll loop issues a read every third cycle
  AST_TOGGLE: assert property (rd_en && busy ##3 rd_en && busy |=>
    rd_data[6] != $past(rd_data[6], 2))
    else $error("toggle bit frozen");
  AST_ABORT_CLEAR: assert property (aborted && wr_en && wr_data == wbps_pkg::CMD_RESET &&
    wr_addr == wbps_pkg::UNLK1_ADDR && $past(wr_data) == wbps_pkg::UNLK2_DATA |=> !aborted)
    else $error("abort reset ignored");
  AST_LIMIT_HOLD: assert property (limit_hit && !(wr_en && wr_data == wbps_pkg::CMD_RESET)
    |=> limit_hit)
    else $error("limit halt left early");
  AST_LIMIT_STATUS: assert property (rd_en && limit_hit |=> rd_data[5])
    else $error("limit bit missing");
endmodule : wbps_checker

// ---- test_write_buffer_program_sequencer.sv ----
/*
 Testbench: host controller and sequencer joined, driven over AHB-Lite.
 Assumes zero-wait host slave and a shortened program time per word.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module test_write_buffer_program_sequencer;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hready, hresp, irq, aborted, limit_hit, dbusy;
  logic [27:0] wq[$];
  int err_count = 0, num_checks = 0;
  always #50 hclk = ~hclk;
  wbps_if i_wbps_if ();
  wbps_host i_wbps_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .irq, .bus(i_wbps_if.host));
  // Short program time keeps suspend reachable and the run brief
  wbps_device #(.PROG_CYC(4)) i_wbps_device (.hclk, .hresetn, .bus(i_wbps_if.dev),
    .busy(dbusy), .aborted, .limit_hit);
  wbps_checker i_wbps_checker (.hclk, .hresetn, .wr_en(i_wbps_if.wr_en),
    .wr_addr(i_wbps_if.wr_addr), .wr_data(i_wbps_if.wr_data), .rd_en(i_wbps_if.rd_en),
    .rd_addr(i_wbps_if.rd_addr), .rd_data(i_wbps_if.rd_data),
    .rd_valid(i_wbps_if.rd_valid), .busy(i_wbps_if.busy), .aborted, .limit_hit);
  always @(posedge hclk) if (i_wbps_if.wr_en === 1'b1)
    wq.push_back({i_wbps_if.wr_addr, i_wbps_if.wr_data});

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb

  task automatic chk_irq(input logic e);
    @(negedge hclk);
    `CHK("irq", e, irq)
    @(posedge hclk);
  endtask : chk_irq

  task automatic prog(input logic [11:0] b, input logic [5:0] c, input logic [15:0] d,
    input logic [2:0] x, input logic sus);
    int n;
    int k;
    n = (c > 31) ? 32 : c + 1;
    ahb(1, wbps_pkg::REG_IRQ_MASK, 32'h7);
    for (k = 0; k < n; k++) ahb(1, wbps_pkg::REG_DATA, {16'h0, d});
    ahb(1, wbps_pkg::REG_BASE, {20'h0, b});
    ahb(1, wbps_pkg::REG_COUNT, {26'h0, c});
    wq.delete();
    ahb(1, wbps_pkg::REG_CTRL, 32'h1);
    if (sus) begin
      for (k = 0; k < 100 && q[1] !== 1'b1; k++) ahb(0, wbps_pkg::REG_CTRL, 0);
      ahb(1, wbps_pkg::REG_CTRL, 32'h4);
      repeat (4) @(posedge hclk);
      ahb(0, wbps_pkg::REG_CTRL, 0);
      `CHK("flash busy", 1'b0, q[1])
      `CHK("dev busy", 1'b0, dbusy)
      ahb(1, wbps_pkg::REG_CTRL, 32'h8);
    end
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge hclk);
    ahb(0, wbps_pkg::REG_IRQ_STAT, 0);
    `CHK("irq stat", {29'h0, x}, q)
    ahb(0, wbps_pkg::REG_LAST, 0);
    if (x == 3'h1) `CHK("last", {16'h0, d}, q)
    else begin
      `CHK("abort bit", x[1], q[1])
      `CHK("limit bit", x[2], q[5])
      `CHK("poll bit", ~d[7], q[7])
    end
    if (x == 3'h1) begin
      `CHK("writes", n + (sus ? 7 : 5), wq.size())
      `CHK("unlock1", {12'h555, 16'h00AA}, wq[0])
      `CHK("unlock2", {12'h2AA, 16'h0055}, wq[1])
      `CHK("load cmd", {b, 16'h0025}, wq[2])
      `CHK("count", {b, 10'h0, c}, wq[3])
      `CHK("confirm", {b, 16'h0029}, wq[n + 4])
    end
    ahb(1, wbps_pkg::REG_IRQ_MASK, 0);
    chk_irq(1'b0);
    ahb(1, wbps_pkg::REG_IRQ_MASK, 32'h7);
    chk_irq(1'b1);
    ahb(1, wbps_pkg::REG_IRQ_STAT, 32'h7);
    chk_irq(1'b0);
    if (x != 3'h1) begin
      ahb(1, wbps_pkg::REG_CTRL, 32'h2);
      repeat (4) @(posedge hclk);
      for (k = 0; k < 40; k++) begin
        ahb(0, wbps_pkg::REG_CTRL, 0);
        if (q[0] === 1'b0) break;
      end
      `CHK("aborted", 1'b0, aborted)
      `CHK("limit", 1'b0, limit_hit)
    end
  endtask : prog

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    #3000000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, wbps_pkg::REG_IRQ_MASK, 0);
    `CHK("mask reset", 32'h0, q)
    ahb(1, 8'h1C, 32'hFFFF_FFFF);
    ahb(0, 8'h1C, 0);
    `CHK("unmapped", 32'h0, q)
    prog(12'h340, 6'd2, 16'hF0F0, 3'h1, 1'b0);
    prog(12'h340, 6'd2, 16'h00F0, 3'h1, 1'b0);
    prog(12'h3A0, 6'd31, 16'h5A5A, 3'h1, 1'b1);
    prog(12'h35E, 6'd3, 16'h1234, 3'h2, 1'b0);
    // Count abort loads nothing: poll bit still reflects the last accepted load
    prog(12'h400, 6'd32, 16'h0070, 3'h2, 1'b0);
    prog(12'h341, 6'd0, 16'hFFFF, 3'h4, 1'b0);
    prog(12'h600, 6'd0, 16'h0001, 3'h1, 1'b0);
    finish_test();
  end
endmodule : test_write_buffer_program_sequencer
